// file: verilog/pss_pkg.sv
// Shared constants and types of the pipelined synchronous memory port
package pss_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int PSS_ADDR_W     = 16;
  localparam int PSS_DATA_W     = 32;
  localparam int PSS_LANES      = 4;
  localparam int PSS_BYTE_W     = 8;
  localparam int PSS_CNT_W      = 2;
  localparam int PSS_FIFO_DEPTH = 4;

  // ****************************************************************
  // Values after reset, counter step and fixed lane patterns
  // ****************************************************************
  localparam logic [PSS_CNT_W-1:0]  PSS_CNT_RST   = 2'h0;
  localparam logic [PSS_CNT_W-1:0]  PSS_CNT_ONE   = 2'h1;
  localparam logic [PSS_LANES-1:0]  PSS_LANES_ALL = 4'hf;
  localparam logic [PSS_LANES-1:0]  PSS_LANES_NONE = 4'h0;
  localparam logic [PSS_DATA_W-1:0] PSS_DATA_RST  = 32'h0000_0000;

  // Burst order strap levels
  typedef enum logic {
    PSS_ORDER_LINEAR      = 1'b0,
    PSS_ORDER_INTERLEAVED = 1'b1
  } pss_order_t;

endpackage

// file: verilog/pss_sram_port.sv
// Pipelined synchronous memory port with read-data FIFO
`timescale 1ns/10ps

// What this block does
// R1 - Register all synchronous inputs on rising clock
// R2 - Inputs and read data pass register stages
// R3 - First beat after three clocks, then one each
// R4 - Load address only on a strobe edge
// R5 - Sixty-four K words of 32 bits
// R6 - Low address bits seed the burst counter
// R7 - Counter advances only with advance low
// R8 - Interleaved or linear order by strap
// R9 - Writes use registered address, data, controls
// R10 - One to four byte lanes per write
// R11 - Global write stores all four bytes
// R12 - Byte write needs enable low, lanes select
// R13 - Processor strobe ignored while first select high
// R14 - Chip selects looked at only on loads
// R15 - All three selects active or deselect
// R16 - Output enable and sleep act asynchronously; sleep here only gates the clocked enables at the next rising edge
// R17 - Both strobes together: processor strobe wins
// R18 - Burst order strap stays static
// R19 - Drive data while output enable low
// R20 - Sleep holds contents and stops activity
// R21 - Burst wraps in its four-word group

// ******************************************************************
// Read-data FIFO
// ******************************************************************
module pss_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  // Filling side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Draining side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW:0]   FULL_CNT = (AW+1)'(D);
  localparam logic [AW-1:0] LAST_PTR = AW'(D - 1);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic          push_w;
  logic          pop_w;

  assign o_in_ready  = (count_reg != FULL_CNT);
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = mem[rd_ptr_reg];
  assign push_w      = i_in_valid & o_in_ready;
  assign pop_w       = o_out_valid & i_out_ready;

  always_ff @(posedge i_mclk) begin
    if (push_w) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push_w) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop_w) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push_w) - (AW+1)'(pop_w);
    end
  end

  // A push into a full FIFO is refused, so no unread word is overwritten
  a_fifo_bound: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R2
    count_reg <= FULL_CNT)
    else $error("read FIFO count beyond its depth");
endmodule

// ******************************************************************
// Memory port
// ******************************************************************
module pss_sram_port (
  // Clock and reset
  input  wire logic                            i_mclk,
  input  wire logic                            i_rst_n,
  // Address and strobes
  input  wire logic [pss_pkg::PSS_ADDR_W-1:0]  i_addr,
  input  wire logic                            i_proc_addr_strobe_n,
  input  wire logic                            i_ctrl_addr_strobe_n,
  input  wire logic                            i_burst_advance_n,
  // Chip selects
  input  wire logic                            i_chip_sel_first_n,
  input  wire logic                            i_chip_sel_second,
  input  wire logic                            i_chip_sel_third_n,
  // Write controls
  input  wire logic [pss_pkg::PSS_LANES-1:0]   i_byte_lane_sel_n,
  input  wire logic                            i_byte_write_en_n,
  input  wire logic                            i_global_write_n,
  // Asynchronous controls and strap
  input  wire logic                            i_out_en_n,
  input  wire logic                            i_sleep_req,
  input  wire logic                            i_burst_order,
  // Shared data lines
  input  wire logic [pss_pkg::PSS_DATA_W-1:0]  i_dq,
  output logic      [pss_pkg::PSS_DATA_W-1:0]  o_dq,
  output logic                                 o_dq_oe,
  output logic                                 o_read_valid
);
  import pss_pkg::*;

  localparam int WORDS = 2 ** PSS_ADDR_W;
  localparam int UPW   = PSS_ADDR_W - PSS_CNT_W;

  // ****************************************************************
  // Input decode
  // ****************************************************************
  logic                  active_reg;
  logic [UPW-1:0]        base_reg;
  logic [PSS_CNT_W-1:0]  start_reg;
  logic [PSS_CNT_W-1:0]  step_reg;
  logic                  desel_reg;
  logic                  acc_valid_reg;
  logic [PSS_ADDR_W-1:0] acc_addr_reg;
  logic [PSS_LANES-1:0]  acc_we_reg;
  logic [PSS_DATA_W-1:0] acc_wdata_reg;
  logic                  oe_mask_reg;
  logic                  drive_reg;
  logic [PSS_DATA_W-1:0] dq_reg;

  logic                  selected_w;
  logic                  proc_take_w;
  logic                  strobe_w;
  logic                  awake_w;
  logic                  stall_w;
  logic                  load_w;
  logic                  adv_w;
  logic                  go_w;
  logic [PSS_CNT_W-1:0]  step_next_w;
  logic [PSS_CNT_W-1:0]  burst_bits_w;
  logic [PSS_ADDR_W-1:0] go_addr_w;
  logic [PSS_LANES-1:0]  we_w;
  logic                  acc_read_w;
  logic [PSS_DATA_W-1:0] rd_word_w;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic [PSS_DATA_W-1:0] fifo_out_data;
  logic                  pop_w;

  assign selected_w  = !i_chip_sel_first_n & i_chip_sel_second & !i_chip_sel_third_n; // R15
  assign proc_take_w = !i_proc_addr_strobe_n & !i_chip_sel_first_n; // R13
  // A processor strobe taken wins; its address is the same pins either way
  assign strobe_w    = proc_take_w | !i_ctrl_addr_strobe_n; // R17
  // Sleep bypasses the input registers so it bites on the current edge
  assign awake_w     = !i_sleep_req; // R16
  // A read that cannot enter a full FIFO holds the whole input stage
  assign stall_w     = acc_valid_reg & acc_read_w & !fifo_in_ready;
  assign load_w      = strobe_w & awake_w & !stall_w; // R4
  assign adv_w       = !strobe_w & active_reg & !i_burst_advance_n & awake_w & !stall_w; // R7
  assign step_next_w = step_reg + PSS_CNT_ONE; // R21
  assign burst_bits_w = (i_burst_order == PSS_ORDER_INTERLEAVED) ?
                        (start_reg ^ step_next_w) :
                        (start_reg + step_next_w); // R8
  assign go_w        = (load_w & selected_w) | adv_w; // R14
  assign go_addr_w   = load_w ? i_addr : {base_reg, burst_bits_w}; // R5
  assign we_w        = !i_global_write_n  ? PSS_LANES_ALL :
                       !i_byte_write_en_n ? ~i_byte_lane_sel_n :
                                            PSS_LANES_NONE; // R11 R12
  assign acc_read_w  = (acc_we_reg == PSS_LANES_NONE);

  // ****************************************************************
  // Burst address state
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      active_reg <= 1'b0;
      base_reg   <= '0;
      start_reg  <= PSS_CNT_RST;
      step_reg   <= PSS_CNT_RST;
      desel_reg  <= 1'b1;
    end else if (load_w) begin
      active_reg <= selected_w; // R15
      desel_reg  <= !selected_w;
      if (selected_w) begin
        base_reg  <= i_addr[PSS_ADDR_W-1:PSS_CNT_W];
        start_reg <= i_addr[PSS_CNT_W-1:0]; // R6
        step_reg  <= PSS_CNT_RST;
      end
    end else if (adv_w) begin
      step_reg <= step_next_w; // R7 R21
    end
  end

  // ****************************************************************
  // Input register stage
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_valid_reg <= 1'b0;
      acc_addr_reg  <= '0;
      acc_we_reg    <= PSS_LANES_NONE;
      acc_wdata_reg <= PSS_DATA_RST;
    end else if (!stall_w) begin
      acc_valid_reg <= go_w; // R1
      acc_addr_reg  <= go_addr_w;
      acc_we_reg    <= we_w; // R9
      acc_wdata_reg <= i_dq;
    end
  end

  // ****************************************************************
  // Storage, one array per byte lane
  // ****************************************************************
  for (genvar g = 0; g < PSS_LANES; g++) begin : g_lane
    logic [PSS_BYTE_W-1:0] lane_mem [WORDS];

    // Self-timed write from the registered stage only
    always_ff @(posedge i_mclk) begin
      if (acc_valid_reg && acc_we_reg[g]) begin
        lane_mem[acc_addr_reg] <= acc_wdata_reg[g*PSS_BYTE_W +: PSS_BYTE_W]; // R9 R10
      end
    end

    assign rd_word_w[g*PSS_BYTE_W +: PSS_BYTE_W] = lane_mem[acc_addr_reg];
  end

  // ****************************************************************
  // Read-data path
  // ****************************************************************
  pss_fifo #(
    .W (PSS_DATA_W),
    .D (PSS_FIFO_DEPTH)
  ) u_rd_fifo (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (acc_valid_reg & acc_read_w),
    .i_in_data   (rd_word_w),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (awake_w)
  );

  // Sleep stops draining, so data in flight waits in the FIFO
  assign pop_w = fifo_out_valid & awake_w; // R20

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dq_reg      <= PSS_DATA_RST;
      drive_reg   <= 1'b0;
      oe_mask_reg <= 1'b0;
    end else begin
      drive_reg   <= pop_w; // R2 R3
      oe_mask_reg <= load_w & selected_w & desel_reg & (we_w == PSS_LANES_NONE);
      if (pop_w) begin
        dq_reg <= fifo_out_data;
      end
    end
  end

  assign o_dq         = dq_reg;
  assign o_read_valid = drive_reg;
  // Output enable must act without a clock, so it gates the flop here
  assign o_dq_oe      = drive_reg & !i_out_en_n & !oe_mask_reg; // R16 R19

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_first_beat_lat: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R3
    (load_w && selected_w && we_w == PSS_LANES_NONE && !acc_valid_reg && !fifo_out_valid
     ##1 1'b1 ##1 !i_sleep_req) |-> ##1 o_read_valid)
    else $error("first read beat not after three clocks");

  a_proc_ignored: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R13
    (!i_proc_addr_strobe_n && i_chip_sel_first_n && i_ctrl_addr_strobe_n) |-> !load_w)
    else $error("processor strobe taken with first select high");

  a_deselect_load: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R15
    (load_w && !selected_w) |=> (!active_reg && !acc_valid_reg))
    else $error("deselected load left port active");

  a_counter_seed: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R6
    (load_w && selected_w) |=> (start_reg == $past(i_addr[1:0]) && step_reg == PSS_CNT_RST))
    else $error("burst counter not seeded from low address bits");

  a_burst_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R7
    (!load_w && i_burst_advance_n) |=> $stable(step_reg))
    else $error("burst counter moved without advance");

  a_burst_wrap: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R21
    (adv_w ##1 adv_w ##1 adv_w ##1 adv_w) |=> (step_reg == $past(step_reg, 4)
     && $stable(base_reg)))
    else $error("burst left its four-word group");

  a_global_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R11
    (go_w && !stall_w && !i_global_write_n) |=> (acc_valid_reg && acc_we_reg == PSS_LANES_ALL))
    else $error("global write did not select all lanes");

  a_byte_write_en: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R12
    (go_w && !stall_w && i_global_write_n && i_byte_write_en_n) |=> acc_read_w)
    else $error("byte write without enable");

  a_sleep_freeze: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R20
    i_sleep_req |=> (!o_read_valid && !acc_valid_reg))
    else $error("activity during sleep");

  a_oe_float: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R19
    (i_out_en_n || !o_read_valid) |-> !o_dq_oe)
    else $error("data lines driven while disabled");

  a_write_regs: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R9
    (load_w && selected_w) |=> (acc_addr_reg == $past(i_addr) && acc_wdata_reg == $past(i_dq)))
    else $error("access stage did not capture address and data");

  a_lane_select: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R10
    (go_w && !stall_w && i_global_write_n && !i_byte_write_en_n) |=>
     (acc_we_reg == ~$past(i_byte_lane_sel_n)))
    else $error("byte lanes differ from lane selects");

  a_order_inter: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R8
    (adv_w && i_burst_order && step_reg == PSS_CNT_RST) |=>
     (acc_addr_reg[1:0] == ($past(start_reg) ^ 2'h1)))
    else $error("interleaved burst step wrong");

  a_order_linear: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R8
    (adv_w && !i_burst_order && step_reg == PSS_CNT_RST) |=>
     (acc_addr_reg[1:0] == $past(start_reg) + 2'h1))
    else $error("linear burst step wrong");

  a_burst_upper: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R21
    adv_w |=> (acc_addr_reg[PSS_ADDR_W-1:PSS_CNT_W] == $past(base_reg)))
    else $error("burst changed upper address bits");
endmodule

// file: bench/pss_host_model.sv
// Bus master model that drives the memory port from the far side
`timescale 1ns/10ps
module pss_host_model (
  // Clock
  input  wire logic                          i_mclk,
  // Address, strobes and selects
  output logic [pss_pkg::PSS_ADDR_W-1:0]     o_addr,
  output logic                               o_proc_addr_strobe_n,
  output logic                               o_ctrl_addr_strobe_n,
  output logic                               o_burst_advance_n,
  output logic                               o_chip_sel_first_n,
  output logic                               o_chip_sel_second,
  output logic                               o_chip_sel_third_n,
  // Write controls and data
  output logic [pss_pkg::PSS_LANES-1:0]      o_byte_lane_sel_n,
  output logic                               o_byte_write_en_n,
  output logic                               o_global_write_n,
  output logic [pss_pkg::PSS_DATA_W-1:0]     o_dq
);
  import pss_pkg::*;
  initial begin
    {o_proc_addr_strobe_n, o_ctrl_addr_strobe_n, o_burst_advance_n} = 3'h7;
    {o_chip_sel_first_n, o_chip_sel_second, o_chip_sel_third_n} = 3'h2;
    {o_global_write_n, o_byte_write_en_n, o_byte_lane_sel_n} = 6'h3f;
    o_addr = '0;
    o_dq = '0;
  end
  // Present one access; the port samples it at the next rising edge
  task automatic req(input logic [1:0] st, input logic [2:0] sel, input logic [15:0] a,
                     input logic [5:0] w, input logic [31:0] d);
    @(posedge i_mclk);
    #1;
    {o_proc_addr_strobe_n, o_ctrl_addr_strobe_n} = ~st;
    {o_chip_sel_first_n, o_chip_sel_second, o_chip_sel_third_n} = sel;
    {o_global_write_n, o_byte_write_en_n, o_byte_lane_sel_n} = w;
    o_addr = a;
    o_dq = d;
    o_burst_advance_n = 1'b1;
  endtask
  // Address, data, select and lane lines flip so a stale value can never pass for a held one; strobes and write enables go inactive
  task automatic step(input logic adv_n);
    @(posedge i_mclk);
    #1;
    {o_proc_addr_strobe_n, o_ctrl_addr_strobe_n} = 2'h3;
    {o_global_write_n, o_byte_write_en_n} = 2'h3;
    o_byte_lane_sel_n = ~o_byte_lane_sel_n;
    {o_chip_sel_first_n, o_chip_sel_second, o_chip_sel_third_n} =
      ~{o_chip_sel_first_n, o_chip_sel_second, o_chip_sel_third_n};
    o_addr = ~o_addr;
    o_dq = ~o_dq;
    o_burst_advance_n = adv_n;
  endtask
endmodule

// file: bench/pss_sram_port_tb.sv
// Self-checking bench for the pipelined synchronous memory port
`timescale 1ns/10ps
module pss_sram_port_tb;
  import pss_pkg::*;
  localparam logic [2:0] SEL_ON = 3'h2;
  logic                  i_mclk, i_rst_n, i_out_en_n, i_sleep_req, i_burst_order;
  logic [PSS_ADDR_W-1:0] addr;
  logic [PSS_DATA_W-1:0] wdata, o_dq;
  logic [PSS_LANES-1:0]  byte_lane_sel_n;
  logic                  proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n;
  logic                  chip_sel_first_n, chip_sel_second, chip_sel_third_n;
  logic                  byte_write_en_n, global_write_n, o_dq_oe, o_read_valid;
  int                    fail_count = 0, tests_run = 0, cyc = 0;
  logic [PSS_DATA_W-1:0] mem [int];
  logic [PSS_DATA_W-1:0] beat_q[$];
  int                    tq[$];
  logic                  oeq[$];

  pss_host_model host_u (.i_mclk(i_mclk), .o_addr(addr), .o_dq(wdata),
    .o_proc_addr_strobe_n(proc_addr_strobe_n), .o_ctrl_addr_strobe_n(ctrl_addr_strobe_n),
    .o_burst_advance_n(burst_advance_n), .o_chip_sel_first_n(chip_sel_first_n),
    .o_chip_sel_second(chip_sel_second), .o_chip_sel_third_n(chip_sel_third_n),
    .o_byte_lane_sel_n(byte_lane_sel_n), .o_byte_write_en_n(byte_write_en_n),
    .o_global_write_n(global_write_n));
  pss_sram_port dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(addr),
    .i_proc_addr_strobe_n(proc_addr_strobe_n), .i_ctrl_addr_strobe_n(ctrl_addr_strobe_n),
    .i_burst_advance_n(burst_advance_n), .i_chip_sel_first_n(chip_sel_first_n),
    .i_chip_sel_second(chip_sel_second), .i_chip_sel_third_n(chip_sel_third_n),
    .i_byte_lane_sel_n(byte_lane_sel_n), .i_byte_write_en_n(byte_write_en_n),
    .i_global_write_n(global_write_n), .i_out_en_n(i_out_en_n), .i_sleep_req(i_sleep_req),
    .i_burst_order(i_burst_order), .i_dq(wdata), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
    .o_read_valid(o_read_valid));

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // Beats are stamped with the edge that samples them
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (o_read_valid === 1'b1) begin
      beat_q.push_back(o_dq);
      tq.push_back(cyc);
      oeq.push_back(o_dq_oe);
    end
  end

  task automatic end_sim();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp, input string m);
    tests_run++;
    if (got != exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %0d want %0d", $time, m, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) host_u.step(1'b1);
  endtask
  // Write, and mirror in the expected array what the port should store
  task automatic wr(input logic [1:0] st, input logic [2:0] sel, input logic [15:0] a,
                    input logic [5:0] w, input logic [31:0] d);
    host_u.req(st, sel, a, w, d);
    host_u.step(1'b1);
    if (sel == SEL_ON && !i_sleep_req) begin
      for (int g = 0; g < 4; g++) begin
        if (!w[5] || (!w[4] && !w[g])) mem[a][8*g +: 8] = d[8*g +: 8];
      end
    end
  endtask
  // Burst read; adv_n gives the advance level on the four edges after the load
  task automatic rd(input logic [1:0] st, input logic [15:0] a, input logic [3:0] adv_n,
                    input logic oe);
    int et[$];
    int t0;
    logic [1:0] lo;
    beat_q.delete();
    tq.delete();
    oeq.delete();
    host_u.req(st, SEL_ON, a, 6'h3f, 32'h0);
    t0 = cyc;
    et.push_back(t0 + 3);
    for (int i = 0; i < 4; i++) begin
      host_u.step(adv_n[i]);
      if (!adv_n[i]) et.push_back(t0 + 4 + i);
    end
    for (int i = 0; i < 40 && beat_q.size() < et.size(); i++) idle(1);
    idle(3);
    chk_n(beat_q.size(), et.size(), "beat count");
    if (beat_q.size() != et.size()) end_sim();
    for (int j = 0; j < et.size(); j++) begin
      lo = i_burst_order ? a[1:0] ^ j[1:0] : a[1:0] + j[1:0];
      chk_w(beat_q[j], mem[{a[15:2], lo}], "beat data");
      chk_n(tq[j], et[j], "beat edge");
      chk_w(oeq[j], !oe, "drive enable");
    end
  endtask

  task automatic t_burst();
    logic [15:0] lo_a, hi_a;
    for (int g = 0; g < 4; g++) begin
      lo_a = 16'h05a4 + 16'(g);
      hi_a = 16'hfffc + 16'(g);
      wr(g[0] ? 2'h2 : 2'h1, SEL_ON, lo_a, 6'h1f, {lo_a, 16'hf0f0});
      wr(2'h1, SEL_ON, hi_a, 6'h1f, {hi_a, 16'h0f0f});
    end
    for (int o = 1; o >= 0; o--) begin
      i_burst_order = o[0];
      rd(2'h1, 16'h05a5, 4'h8, 1'b0);
      rd(2'h2, 16'h05a6, 4'h0, 1'b0);
      rd(2'h3, 16'hffff, 4'h9, 1'b0);
    end
    $display("burst test done");
  endtask
  task automatic t_bytes();
    wr(2'h1, SEL_ON, 16'h05a4, 6'h2a, 32'hdead_beef);
    wr(2'h2, SEL_ON, 16'h05a5, 6'h30, 32'h1234_5678);
    wr(2'h1, SEL_ON, 16'h05a6, 6'h0f, 32'hcafe_f00d);
    wr(2'h2, SEL_ON, 16'h05a7, 6'h20, 32'h8765_4321);
    rd(2'h2, 16'h05a4, 4'h8, 1'b0);
    $display("byte write test done");
  endtask
  task automatic t_desel();
    wr(2'h1, 3'h6, 16'h05a4, 6'h1f, 32'h0bad_0001);
    wr(2'h1, 3'h0, 16'h05a5, 6'h1f, 32'h0bad_0002);
    wr(2'h1, 3'h3, 16'h05a6, 6'h1f, 32'h0bad_0003);
    wr(2'h2, 3'h6, 16'h05a7, 6'h1f, 32'h0bad_0004);
    beat_q.delete();
    host_u.req(2'h1, 3'h0, 16'h05a4, 6'h3f, 32'h0);
    repeat (6) host_u.step(1'b0);
    chk_n(beat_q.size(), 0, "deselected beats");
    rd(2'h1, 16'h05a4, 4'h8, 1'b0);
    $display("deselect test done");
  endtask
  task automatic t_sleep();
    i_out_en_n = 1'b1;
    rd(2'h1, 16'hfffc, 4'h8, 1'b1);
    i_out_en_n = 1'b0;
    i_sleep_req = 1'b1;
    wr(2'h1, SEL_ON, 16'hfffd, 6'h1f, 32'h5555_aaaa);
    beat_q.delete();
    host_u.req(2'h1, SEL_ON, 16'hfffc, 6'h3f, 32'h0);
    idle(6);
    chk_n(beat_q.size(), 0, "beats while asleep");
    i_sleep_req = 1'b0;
    rd(2'h2, 16'hfffc, 4'h8, 1'b0);
    $display("sleep and enable test done");
  endtask

  initial begin
    {i_rst_n, i_out_en_n, i_sleep_req, i_burst_order} = 4'h1;
    repeat (8) @(posedge i_mclk);
    #1;
    chk_w(o_read_valid, 1'b0, "valid in reset");
    chk_w(o_dq_oe, 1'b0, "enable in reset");
    chk_w(o_dq, PSS_DATA_RST, "data in reset");
    i_rst_n = 1'b1;
    t_burst();
    t_bytes();
    t_desel();
    t_sleep();
    end_sim();
  end
endmodule
